// *** hw/mrc_pkg.sv ***
// Function
// RL1: Abort frames longer than 14-bit programmed maximum.
// RL2: Maximum length resets to 1518 bytes.
// RL3: Watchdog truncates frames beyond 11264 bytes always.
// RL4: Select 0 cuts at maximum plus one.
// RL5: Select 1 cuts at 11265, flags watchdog.
// RL6: Strip final four bytes when enabled.
// RL7: Enforcement off: abort all frames over maximum.
// RL8: Enforcement on: allow four per VLAN tag.
// RL9: Software keeps settings stable while receiver enabled.
// RL10: Enable bit gates frame acceptance; resets clear.
// RL11: Disabling mid-frame finishes that frame first.
// RL12: Disabled flag set on completion, write clears.
// RL13: Reserved bits read zero, ignore writes.
package mrc_pkg;
  localparam logic [11:0] OFS_RX_CTRL = 12'h104;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h120;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h124;
  localparam int POS_ENABLE = 0;
  localparam int POS_DISABLED = 1;
  localparam int POS_VLAN_ENF = 2;
  localparam int POS_FCS_STRIP = 4;
  localparam int POS_TRUNC_SEL = 5;
  localparam int POS_MAX_LO = 16;
  localparam int POS_MAX_HI = 29;
  localparam int IRQ_DISABLED = 0;
  localparam int IRQ_LONG = 1;
  localparam int IRQ_WATCHDOG = 2;
  localparam logic [13:0] RST_MAX_SIZE = 14'd1518;
  localparam logic RST_TRUNC_SEL = 1'b1;
  localparam logic [15:0] WD_CUT_LEN = 16'd11265;
  localparam logic [15:0] VLAN_EXTRA = 16'h0004;
  localparam logic [7:0] TPID_HI = 8'h81;
  localparam logic [7:0] TPID_LO = 8'h00;
  localparam int FCS_BYTES = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** hw/mrc_rx.sv ***
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
module mrc_rx (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phy_rx_dv,
  input wire logic [7:0] phy_rx_data,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic cmd_valid,
  output logic [13:0] cmd_len,
  output logic cmd_long,
  output logic cmd_rwt,
  output logic irq
);

  typedef enum logic [1:0] {MRC_IDLE, MRC_RECV, MRC_DROP} mrc_state_e;

  logic [1:0] rst_sync;
  logic rst_n;
  logic [8:0] pin_q1, pin_q2;
  logic dv;
  logic dv_prev;
  logic [7:0] din;
  logic receiver_enable;
  logic enable_prev, disable_pending;
  logic rx_disabled;
  logic vlan_size_enforce;
  logic fcs_strip;
  logic truncation_length_select;
  logic [13:0] max_size;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_ctrl, wr_stat;
  logic [31:0] ctrl_view;
  mrc_state_e state;
  logic [15:0] cnt;
  logic [1:0] tags;
  logic frame_long, frame_rwt;
  logic [15:0] limit, cut_len;
  logic tpid_hi_seen;
  logic byte_in, frame_start;
  logic frame_end;
  logic ev_long, ev_rwt, ev_disabled;
  logic [7:0] pipe [mrc_pkg::FCS_BYTES];
  logic [2:0] fill;

  // Reset release passes two flip-flops.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // PHY pins are resynchronised; only the second stage is read.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q1 <= 9'h000;
      pin_q2 <= 9'h000;
      dv_prev <= 1'b0;
    end else begin
      pin_q1 <= {phy_rx_dv, phy_rx_data};
      pin_q2 <= pin_q1;
      dv_prev <= pin_q2[8];
    end
  end
  assign dv = pin_q2[8];
  assign din = pin_q2[7:0];

  // AXI4-Lite write path: address and data are taken in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl = wr_fire && (aw_addr == mrc_pkg::OFS_RX_CTRL);
  assign wr_stat = wr_fire && (aw_addr == mrc_pkg::OFS_IRQ_STATUS);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mrc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == mrc_pkg::OFS_RX_CTRL || aw_addr == mrc_pkg::OFS_IRQ_STATUS ||
            aw_addr == mrc_pkg::OFS_IRQ_MASK) begin
          s_axi_bresp <= mrc_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= mrc_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control fields; reserved bits are never stored.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receiver_enable <= 1'b0;
      vlan_size_enforce <= 1'b0;
      fcs_strip <= 1'b0;
      truncation_length_select <= mrc_pkg::RST_TRUNC_SEL;
      max_size <= mrc_pkg::RST_MAX_SIZE; // RL2
      irq_mask <= 3'b000;
    end else begin
      if (wr_ctrl && w_strb[0]) begin // RL13
        receiver_enable <= w_data[mrc_pkg::POS_ENABLE];
        vlan_size_enforce <= w_data[mrc_pkg::POS_VLAN_ENF];
        fcs_strip <= w_data[mrc_pkg::POS_FCS_STRIP];
        truncation_length_select <= w_data[mrc_pkg::POS_TRUNC_SEL];
      end
      if (wr_ctrl && w_strb[2]) begin
        max_size[7:0] <= w_data[mrc_pkg::POS_MAX_LO +: 8];
      end
      if (wr_ctrl && w_strb[3]) begin
        max_size[13:8] <= w_data[mrc_pkg::POS_MAX_HI -: 6];
      end
      if (wr_fire && aw_addr == mrc_pkg::OFS_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[2:0];
      end
    end
  end

  // Graceful disable: the open frame finishes before the flag rises.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enable_prev <= 1'b0;
      disable_pending <= 1'b0;
    end else begin
      enable_prev <= receiver_enable;
      if (enable_prev && !receiver_enable) begin
        disable_pending <= 1'b1;
      end else if (receiver_enable || ev_disabled) begin
        disable_pending <= 1'b0;
      end
    end
  end
  assign ev_disabled = disable_pending && !receiver_enable && (state == MRC_IDLE); // RL11

  // Event flags: a set in the same cycle as a clearing write wins.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_disabled <= 1'b0;
      irq_status <= 3'b000;
    end else begin
      if (ev_disabled) begin
        rx_disabled <= 1'b1; // RL12
      end else if (wr_ctrl && w_strb[0] && w_data[mrc_pkg::POS_DISABLED]) begin
        rx_disabled <= 1'b0; // RL12
      end
      for (int i = 0; i < 3; i++) begin
        if (wr_stat && w_strb[0] && w_data[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
      if (ev_disabled) begin
        irq_status[mrc_pkg::IRQ_DISABLED] <= 1'b1;
      end
      if (ev_long) begin
        irq_status[mrc_pkg::IRQ_LONG] <= 1'b1;
      end
      if (ev_rwt) begin
        irq_status[mrc_pkg::IRQ_WATCHDOG] <= 1'b1;
      end
    end
  end
  assign irq = |(irq_status & irq_mask);

  always_comb begin
    ctrl_view = 32'h0000_0000; // RL13
    ctrl_view[mrc_pkg::POS_ENABLE] = receiver_enable;
    ctrl_view[mrc_pkg::POS_DISABLED] = rx_disabled;
    ctrl_view[mrc_pkg::POS_VLAN_ENF] = vlan_size_enforce;
    ctrl_view[mrc_pkg::POS_FCS_STRIP] = fcs_strip;
    ctrl_view[mrc_pkg::POS_TRUNC_SEL] = truncation_length_select;
    ctrl_view[mrc_pkg::POS_MAX_HI:mrc_pkg::POS_MAX_LO] = max_size;
  end

  // AXI4-Lite read path answers one cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= mrc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mrc_pkg::RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'b00})
        mrc_pkg::OFS_RX_CTRL: s_axi_rdata <= ctrl_view;
        mrc_pkg::OFS_IRQ_STATUS: s_axi_rdata <= {29'h0000_0000, irq_status};
        mrc_pkg::OFS_IRQ_MASK: s_axi_rdata <= {29'h0000_0000, irq_mask};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= mrc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Size limit grows by four bytes per VLAN tag when enforcement is on.
  always_comb begin
    if (vlan_size_enforce) begin
      limit = {2'b00, max_size} + 16'(tags) * mrc_pkg::VLAN_EXTRA; // RL8
    end else begin
      limit = {2'b00, max_size}; // RL7
    end
    if (truncation_length_select || limit >= mrc_pkg::WD_CUT_LEN) begin
      cut_len = mrc_pkg::WD_CUT_LEN; // RL3 RL5
    end else begin
      cut_len = limit + 16'h0001; // RL4 RL8
    end
  end

  assign frame_start = dv && !dv_prev && receiver_enable && (state == MRC_IDLE); // RL10
  assign byte_in = frame_start || (dv && (state == MRC_RECV));
  assign frame_end = !dv && dv_prev && (state != MRC_IDLE);
  assign ev_long = frame_end && (frame_long || cnt > limit); // RL1
  assign ev_rwt = frame_end && frame_rwt;

  // Frame receive sequencer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MRC_IDLE;
      cnt <= 16'h0000;
      tags <= 2'b00;
      frame_long <= 1'b0;
      frame_rwt <= 1'b0;
    end else begin
      case (state)
        MRC_IDLE: begin
          if (frame_start) begin // RL10
            state <= MRC_RECV;
            cnt <= 16'h0001;
            tags <= 2'b00;
            frame_long <= 1'b0;
            frame_rwt <= 1'b0;
          end
        end
        MRC_RECV: begin
          if (!dv) begin
            state <= MRC_IDLE;
          end else begin
            cnt <= cnt + 16'h0001;
            if (cnt + 16'h0001 > limit) begin
              frame_long <= 1'b1; // RL1
            end
            if (cnt + 16'h0001 == cut_len) begin
              state <= MRC_DROP;
              frame_long <= 1'b1; // RL4 RL5
              frame_rwt <= (cut_len == mrc_pkg::WD_CUT_LEN); // RL5
            end
          end
        end
        MRC_DROP: begin
          if (!dv) begin
            state <= MRC_IDLE;
          end
        end
        default: state <= MRC_IDLE;
      endcase
      if (dv && state == MRC_RECV && din == mrc_pkg::TPID_LO && tpid_hi_seen &&
          (cnt == 16'd13 || (cnt == 16'd17 && tags == 2'b01))) begin // RL8
        tags <= tags + 2'b01;
      end
    end
  end

  // Remembers whether the byte before a tag position was the tag high byte.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tpid_hi_seen <= 1'b0;
    end else if (byte_in) begin
      tpid_hi_seen <= (din == mrc_pkg::TPID_HI);
    end
  end

  // Four-byte hold-back so the trailing check sequence can be dropped.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fill <= 3'b000;
    end else if (frame_start) begin
      fill <= 3'b001;
    end else if (state == MRC_IDLE) begin
      fill <= 3'b000;
    end else if (byte_in && fill != 3'(mrc_pkg::FCS_BYTES)) begin
      fill <= fill + 3'b001;
    end
  end

  for (genvar g = 0; g < mrc_pkg::FCS_BYTES; g++) begin : g_pipe
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pipe[g] <= 8'h00;
      end else if (byte_in) begin
        pipe[g] <= (g == 0) ? din : pipe[g - ((g == 0) ? 0 : 1)];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= 8'h00;
      cmd_valid <= 1'b0;
      cmd_len <= 14'h0000;
      cmd_long <= 1'b0;
      cmd_rwt <= 1'b0;
    end else begin
      if (fcs_strip) begin
        out_valid <= byte_in && (fill == 3'(mrc_pkg::FCS_BYTES)); // RL6
        out_data <= pipe[mrc_pkg::FCS_BYTES - 1];
      end else begin
        out_valid <= byte_in;
        out_data <= din;
      end
      cmd_valid <= frame_end;
      if (frame_end) begin
        cmd_len <= cnt[13:0];
        cmd_long <= frame_long || (cnt > limit);
        cmd_rwt <= frame_rwt;
      end
    end
  end

endmodule // mrc_rx

// *** tb/mrc_rx_asserts.sv ***
`timescale 1ns/10ps
module mrc_rx_asserts (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic phy_rx_dv,
  input wire logic out_valid,
  input wire logic cmd_valid,
  input wire logic [13:0] cmd_len,
  input wire logic cmd_long,
  input wire logic cmd_rwt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  chk_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
    else $error("request taken while answer pending");
  chk_byte_source: assert property (out_valid |-> $past(phy_rx_dv, 3))
    else $error("byte passed without a received byte");
  chk_cmd_at_end: assert property (cmd_valid |-> $past(phy_rx_dv, 4) && !$past(phy_rx_dv, 3))
    else $error("command word not at frame end");
  chk_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command word longer than one cycle");
  chk_len_cap: assert property (cmd_valid |-> cmd_len <= 14'h2c01 && (!cmd_rwt || cmd_long && cmd_len == 14'h2c01))
    else $error("watchdog length wrong");
endmodule // mrc_rx_asserts
bind mrc_rx mrc_rx_asserts mrc_rx_asserts_inst (.mclk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .phy_rx_dv, .out_valid, .cmd_valid, .cmd_len, .cmd_long, .cmd_rwt);

// *** tb/mrc_phy_model.sv ***
`timescale 1ns/10ps
module mrc_phy_model (
  input wire logic mclk,
  input wire logic start,
  input wire logic [15:0] len,
  input wire logic [1:0] tags,
  output logic phy_rx_dv,
  output logic [7:0] phy_rx_data,
  output logic busy
);
  logic [15:0] idx;
  function automatic logic [7:0] pat(input logic [15:0] i, input logic [1:0] t);
    if (t != 2'h0 && (i == 16'h000c || t == 2'h2 && i == 16'h0010)) return mrc_pkg::TPID_HI;
    if (t != 2'h0 && (i == 16'h000d || t == 2'h2 && i == 16'h0011)) return mrc_pkg::TPID_LO;
    return i[7:0] ^ 8'h5a;
  endfunction
  initial begin
    phy_rx_dv = 1'h0;
    phy_rx_data = 8'h00;
    busy = 1'h0;
    idx = 16'h0000;
  end
  // Outside a frame the data lines toggle so a stale byte is never mistaken for data.
  always @(posedge mclk) begin
    if (start && !busy) begin
      busy <= 1'h1;
      idx <= 16'h0000;
      phy_rx_data <= ~phy_rx_data;
    end else if (busy && idx != len) begin
      phy_rx_dv <= 1'h1;
      phy_rx_data <= pat(idx, tags);
      idx <= idx + 16'h0001;
    end else begin
      busy <= 1'h0;
      phy_rx_dv <= 1'h0;
      phy_rx_data <= ~phy_rx_data;
    end
  end
endmodule // mrc_phy_model

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [31:0] ctl; logic [15:0] n; logic [1:0] t; logic [15:0] eout; logic [13:0] elen;
    logic [2:0] ef;} mrc_row_s;
  logic mclk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, start, busy;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, phy_rx_dv;
  logic out_valid, cmd_valid, cmd_long, cmd_rwt, irq, glong, grwt;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, ftags;
  logic [7:0] phy_rx_data, out_data, first;
  logic [13:0] cmd_len, glen;
  logic [15:0] flen;
  int miscompares, compares, ncmd, nout;
  mrc_row_s rows[10] = '{
    '{32'h0040_0021, 16'h0040, 2'h0, 16'h0040, 14'h0040, 3'h4}, '{32'h0040_0001, 16'h0046, 2'h0, 16'h0041, 14'h0041, 3'h6},
    '{32'h0040_0031, 16'h0040, 2'h0, 16'h003c, 14'h0040, 3'h4}, '{32'h0040_0005, 16'h0044, 2'h1, 16'h0044, 14'h0044, 3'h4},
    '{32'h0040_0005, 16'h004b, 2'h1, 16'h0045, 14'h0045, 3'h6}, '{32'h0040_0005, 16'h0048, 2'h2, 16'h0048, 14'h0048, 3'h4},
    '{32'h0040_0001, 16'h0042, 2'h1, 16'h0041, 14'h0041, 3'h6}, '{32'h0040_0020, 16'h000a, 2'h0, 16'h0000, 14'h0000, 3'h0},
    '{32'h0040_0021, 16'h0046, 2'h0, 16'h0046, 14'h0046, 3'h6}, '{32'h0040_0021, 16'h2c24, 2'h0, 16'h2c01, 14'h2c01, 3'h7}};
  mrc_rx mrc_rx_inst (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phy_rx_dv, .phy_rx_data,
    .out_valid, .out_data, .cmd_valid, .cmd_len, .cmd_long, .cmd_rwt, .irq);
  mrc_phy_model mrc_phy_model_inst (.mclk, .start, .len(flen), .tags(ftags), .phy_rx_dv, .phy_rx_data, .busy);
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (out_valid) begin
      if (nout == 0) first <= out_data;
      nout++;
    end
    if (cmd_valid) begin
      ncmd++;
      glen <= cmd_len;
      glong <= cmd_long;
      grwt <= cmd_rwt;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic axi_w(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axi_r(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic frame(input logic [15:0] n, input logic [1:0] t);
    @(posedge mclk);
    ncmd = 0;
    nout = 0;
    flen <= n;
    ftags <= t;
    start <= 1'h1;
    @(posedge mclk);
    start <= 1'h0;
    do @(posedge mclk); while (busy);
    repeat (8) @(posedge mclk);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'(e));
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    summarize;
  end
  initial begin
    {rstn, start, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, flen, ftags} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ncmd, nout} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge mclk);
    rstn <= 1'h1;
    repeat (3) @(posedge mclk);
    axi_r(mrc_pkg::OFS_RX_CTRL, 32'h05ee_0020, mrc_pkg::RESP_OKAY);
    foreach (rows[i]) begin
      axi_w(mrc_pkg::OFS_RX_CTRL, rows[i].ctl & ~32'h0000_0001, mrc_pkg::RESP_OKAY);
      axi_w(mrc_pkg::OFS_RX_CTRL, rows[i].ctl, mrc_pkg::RESP_OKAY);
      frame(rows[i].n, rows[i].t);
      chk(32'(nout), 32'(rows[i].eout));
      chk(32'(ncmd), 32'(rows[i].ef[2]));
      if (rows[i].ef[2]) begin
        chk(32'(glen), 32'(rows[i].elen));
        chk(32'({glong, grwt}), 32'(rows[i].ef[1:0]));
        chk(32'(first), 32'h0000_005a);
      end
      $display("frame row %0d done", i);
    end
    axi_w(mrc_pkg::OFS_IRQ_STATUS, 32'h0000_0007, mrc_pkg::RESP_OKAY);
    axi_w(mrc_pkg::OFS_IRQ_MASK, 32'h0000_0001, mrc_pkg::RESP_OKAY);
    axi_w(mrc_pkg::OFS_RX_CTRL, 32'h0040_0003, mrc_pkg::RESP_OKAY);
    axi_r(mrc_pkg::OFS_RX_CTRL, 32'h0040_0001, mrc_pkg::RESP_OKAY);
    irq_is(1'h0);
    fork
      frame(16'h0028, 2'h0);
      begin
        repeat (12) @(posedge mclk);
        axi_w(mrc_pkg::OFS_RX_CTRL, 32'h0040_0000, mrc_pkg::RESP_OKAY);
      end
    join
    chk(32'(ncmd), 32'h0000_0001);
    chk(32'(nout), 32'h0000_0028);
    axi_r(mrc_pkg::OFS_RX_CTRL, 32'h0040_0002, mrc_pkg::RESP_OKAY);
    irq_is(1'h1);
    axi_w(mrc_pkg::OFS_IRQ_MASK, 32'h0000_0000, mrc_pkg::RESP_OKAY);
    irq_is(1'h0);
    axi_w(mrc_pkg::OFS_IRQ_MASK, 32'h0000_0001, mrc_pkg::RESP_OKAY);
    irq_is(1'h1);
    axi_w(mrc_pkg::OFS_IRQ_STATUS, 32'h0000_0001, mrc_pkg::RESP_OKAY);
    irq_is(1'h0);
    $display("disable and interrupt test done");
    axi_w(mrc_pkg::OFS_RX_CTRL, 32'hc000_ffc8, mrc_pkg::RESP_OKAY);
    axi_r(mrc_pkg::OFS_RX_CTRL, 32'h0000_0002, mrc_pkg::RESP_OKAY);
    axi_w(12'h200, 32'h0000_0001, mrc_pkg::RESP_SLVERR);
    axi_r(12'h200, 32'h0000_0000, mrc_pkg::RESP_SLVERR);
    $display("reserved and unmapped test done");
    rstn <= 1'h0;
    repeat (4) @(posedge mclk);
    rstn <= 1'h1;
    repeat (3) @(posedge mclk);
    axi_r(mrc_pkg::OFS_RX_CTRL, 32'h05ee_0020, mrc_pkg::RESP_OKAY);
    $display("second reset test done");
    summarize;
  end
endmodule // tb_top
